// [rtl/fli_pkg.sv]
// package for the flash led input configuration and control block
// holds register offsets, field positions, reset values and bus constants
package fli_pkg;
    // register offsets on the serial bus
    localparam logic [7:0] PIN_FUNCTION_CONFIG_ADDR = 8'he0;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_ADDR = 8'hf0;
    localparam logic [7:0] FLAGS_ADDR = 8'hd0;

    // pin_function_config fields
    localparam int HW_TORCH_SEL_BIT = 7;
    localparam int PULSE_TWO_POL_BIT = 6;
    localparam int PULSE_ONE_POL_BIT = 5;
    localparam int THERMAL_MODE_BIT = 4;
    localparam int TRIGGER_POL_BIT = 3;
    localparam int TRIGGER_EN_BIT = 2;

    // fault_response_config fields
    localparam int VIN_OFF_BIT = 3;
    localparam int ALT_TORCH_BIT = 2;
    localparam int THERMAL_OFF_BIT = 1;
    localparam int PULSE_TWO_OFF_BIT = 0;

    // flags fields
    localparam int FLAG_VIN_BIT = 7;
    localparam int FLAG_THERMAL_BIT = 5;
    localparam int FLAG_PULSE_TWO_BIT = 4;
    localparam int FLAG_PULSE_ONE_BIT = 3;

    // reset values and writable masks; unused bits stay zero
    localparam logic [7:0] PIN_FUNCTION_CONFIG_RST = 8'h68;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_RST = 8'h00;
    localparam logic [7:0] PIN_FUNCTION_CONFIG_MASK = 8'hfc;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_MASK = 8'h0f;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [1:0] PIN_SETTLE_CYCLES = 2'h3; // edges to flush a pin synchroniser

    // serial bus framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h53; // arbitrary value

    typedef enum logic [9:0] {
        ST_IDLE = 10'b0000000001,
        ST_ADDR = 10'b0000000010,
        ST_ADDR_ACK = 10'b0000000100,
        ST_REG = 10'b0000001000,
        ST_REG_ACK = 10'b0000010000,
        ST_WDATA = 10'b0000100000,
        ST_WDATA_ACK = 10'b0001000000,
        ST_RDATA = 10'b0010000000,
        ST_RACK = 10'b0100000000,
        ST_HOLD = 10'b1000000000
    } fli_state_t;
endpackage : fli_pkg

// [rtl/fli_sync.sv]
// two-flop synchroniser for a group of unrelated level inputs
// assumes each bit is an independent level; no word coherence is kept
`timescale 1ns/10ps
module fli_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // first stage feeds only the second stage
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : fli_sync

// [rtl/fli_pin_cond.sv]
// conditions one external control pin: synchronise, apply polarity, flag changes
// assumes polarity comes from a register on clk; pin is asynchronous
`timescale 1ns/10ps
module fli_pin_cond (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_raw,
    input wire logic active_high,
    output logic active,
    output logic changed
);
    logic pin_s;
    logic pin_d_r;
    logic pin_d_nxt;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;

    fli_sync #(.W(1)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // delayed copy to see a change of state; changes stay masked until the sync has
    // flushed after reset, so a pin idling high gives no false edge (early ones are lost)
    always_comb begin
        pin_d_nxt = pin_s;
        settle_nxt = settle_r;
        if (settle_r != fli_pkg::PIN_SETTLE_CYCLES) begin
            settle_nxt = settle_r + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_d_r <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            pin_d_r <= pin_d_nxt;
            settle_r <= settle_nxt;
        end
    end

    // polarity: 0 means the pin asserts low
    assign active = pin_s ~^ active_high;
    assign changed = (pin_s ^ pin_d_r) & (settle_r == fli_pkg::PIN_SETTLE_CYCLES);
endmodule : fli_pin_cond

// [rtl/fli_ctrl.sv]
// flash led input configuration and control: serial register slave, pin steering
// assumes scl and sda arrive from pins and are sampled by clk (scl well below clk/8)
// Function
// R01 - bit 7 of pin_function_config picks pulse-one interrupt input (0) or hardware torch (1).
// R02 - a flash event clears the hardware torch select bit back to interrupt use.
// R03 - bits 6 and 5 set active level of pulse inputs two and one, 1 high by default.
// R04 - bit 3 sets the flash trigger input active level, high by default.
// R05 - the flash trigger input is ignored unless bit 2 is set.
// R06 - bit 4 makes the shared pin an indicator output (0) or thermal comparator input (1).
// R07 - a monitored undervoltage forces torch (bit 3 of fault_response_config 0) or leds off.
// R08 - with alternate torch mode, pulse-one high before the trigger gives torch with no timeout.
// R09 - in thermal mode a trip forces torch (bit 1 clear) or shutdown (bit 1 set).
// R10 - a pulse-two event forces torch when bit 0 is 0, shutdown when it is 1.
// R11 - registers live at 0xe0 and 0xf0 with their unused bits reading zero.
// R12 - pulse input changes and thermal trips set status flags the host can read back.
// R13 - the host writes zeros to unused bits and does not trust their read-back; the testbench writes 0xff to 0xe0 and checks the 0xfc read-back.
`timescale 1ns/10ps
module fli_ctrl #(
    parameter logic [6:0] DEV_ADDR = fli_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic torch_or_pulse_one_pin,
    input wire logic pulse_input_two,
    input wire logic flash_trigger_pin,
    input wire logic led_thermal_sense,
    input wire logic input_undervoltage_threshold,
    input wire logic input_voltage_monitor_en,
    input wire logic flash_event,
    output logic torch_pin_enable_o,
    output logic pulse_one_torch_req_o,
    output logic strobe_trigger_o,
    output logic indicator_drive_en_o,
    output logic thermal_comp_en_o,
    output logic led_force_torch_o,
    output logic led_shutdown_o,
    output logic torch_no_timeout_o
);
    logic scl_s, sda_s, vin_low_s, therm_low_s;
    logic scl_d_r, sda_d_r, scl_d_nxt, sda_d_nxt;
    logic p1_active, p1_changed, p2_active, p2_changed, trig_active;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    fli_pkg::fli_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt;
    logic oe_r, oe_nxt, rd_r, rd_nxt;
    logic [7:0] cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt, flags_r, flags_nxt;
    logic wr_stb, flags_rd;
    logic alt_torch_r, alt_torch_nxt;
    logic torch_pin_nxt, p1_req_nxt, trig_nxt, torch_nxt, shut_nxt;

    // bus lines and analog comparator outputs come from outside clk
    fli_sync #(.W(4)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({scl, sda_i, input_undervoltage_threshold, led_thermal_sense}),
        .sync_out({scl_s, sda_s, vin_low_s, therm_low_s})
    );

    // pulse inputs and trigger with programmable active level
    fli_pin_cond u_p1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_raw(torch_or_pulse_one_pin),
        .active_high(cfg1_r[fli_pkg::PULSE_ONE_POL_BIT]), // see R03
        .active(p1_active),
        .changed(p1_changed)
    );
    fli_pin_cond u_p2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_raw(pulse_input_two),
        .active_high(cfg1_r[fli_pkg::PULSE_TWO_POL_BIT]), // see R03
        .active(p2_active),
        .changed(p2_changed)
    );
    fli_pin_cond u_trig (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_raw(flash_trigger_pin),
        .active_high(cfg1_r[fli_pkg::TRIGGER_POL_BIT]), // see R04
        .active(trig_active),
        .changed()
    );

    // bus edge and frame detection on the synchronised lines
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

    function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] c1,
                                            input logic [7:0] c2, input logic [7:0] fl);
        // unmapped offsets read zero
        unique case (addr)
            fli_pkg::PIN_FUNCTION_CONFIG_ADDR: reg_read = c1 & fli_pkg::PIN_FUNCTION_CONFIG_MASK;
            fli_pkg::FAULT_RESPONSE_CONFIG_ADDR:
                reg_read = c2 & fli_pkg::FAULT_RESPONSE_CONFIG_MASK;
            fli_pkg::FLAGS_ADDR: reg_read = fl;
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // serial slave: bits sampled on scl rise, sda changed on scl fall
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        oe_nxt = oe_r;
        rd_nxt = rd_r;
        wr_stb = 1'b0;
        flags_rd = 1'b0;
        if (bus_start) begin
            state_nxt = fli_pkg::ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (bus_stop) begin
            state_nxt = fli_pkg::ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                fli_pkg::ST_IDLE, fli_pkg::ST_HOLD: begin
                    oe_nxt = 1'b0;
                end
                fli_pkg::ST_ADDR, fli_pkg::ST_REG, fli_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == fli_pkg::BITS_PER_BYTE) begin
                        cnt_nxt = 4'h0;
                        oe_nxt = 1'b1; // pull low to acknowledge
                        if (state_r == fli_pkg::ST_ADDR) begin
                            rd_nxt = shift_r[0];
                            if (shift_r[7:1] == DEV_ADDR) begin
                                state_nxt = fli_pkg::ST_ADDR_ACK;
                            end else begin
                                state_nxt = fli_pkg::ST_HOLD;
                                oe_nxt = 1'b0;
                            end
                        end else if (state_r == fli_pkg::ST_REG) begin
                            ptr_nxt = shift_r;
                            state_nxt = fli_pkg::ST_REG_ACK;
                        end else begin
                            wr_stb = 1'b1;
                            state_nxt = fli_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                fli_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rd_r) begin
                            // reading the flags clears them
                            shift_nxt = reg_read(ptr_r, cfg1_r, cfg2_r, flags_r);
                            flags_rd = (ptr_r == fli_pkg::FLAGS_ADDR);
                            oe_nxt = ~shift_nxt[7];
                            state_nxt = fli_pkg::ST_RDATA;
                        end else begin
                            oe_nxt = 1'b0;
                            state_nxt = fli_pkg::ST_REG;
                        end
                    end
                end
                fli_pkg::ST_REG_ACK, fli_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        state_nxt = fli_pkg::ST_WDATA; // further bytes rewrite the same offset
                    end
                end
                fli_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == fli_pkg::BITS_PER_BYTE) begin
                            cnt_nxt = 4'h0;
                            oe_nxt = 1'b0;
                            state_nxt = fli_pkg::ST_RACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt = ~shift_r[6];
                        end
                    end
                end
                fli_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        // a high bit is the master's not-acknowledge
                        state_nxt = sda_s ? fli_pkg::ST_HOLD : fli_pkg::ST_ADDR_ACK;
                    end
                end
                default: begin
                    state_nxt = fli_pkg::ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // configuration, flags and output steering
    always_comb begin
        cfg1_nxt = cfg1_r;
        cfg2_nxt = cfg2_r;
        if (wr_stb && ptr_r == fli_pkg::PIN_FUNCTION_CONFIG_ADDR) begin
            cfg1_nxt = shift_r & fli_pkg::PIN_FUNCTION_CONFIG_MASK; // see R11
        end
        if (wr_stb && ptr_r == fli_pkg::FAULT_RESPONSE_CONFIG_ADDR) begin
            cfg2_nxt = shift_r & fli_pkg::FAULT_RESPONSE_CONFIG_MASK; // see R11
        end
        // the flash event beats a host write in the same cycle
        if (flash_event) begin
            cfg1_nxt[fli_pkg::HW_TORCH_SEL_BIT] = 1'b0; // see R02
        end
        // flags: set wins over the clear-on-read
        flags_nxt = flags_rd ? fli_pkg::FLAGS_RST : flags_r;
        if (p1_changed && !cfg1_r[fli_pkg::HW_TORCH_SEL_BIT]) begin
            flags_nxt[fli_pkg::FLAG_PULSE_ONE_BIT] = 1'b1; // see R12
        end
        if (p2_changed) begin
            flags_nxt[fli_pkg::FLAG_PULSE_TWO_BIT] = 1'b1; // see R12
        end
        if (therm_low_s && cfg1_r[fli_pkg::THERMAL_MODE_BIT]) begin
            flags_nxt[fli_pkg::FLAG_THERMAL_BIT] = 1'b1; // see R12
        end
        if (vin_low_s && input_voltage_monitor_en) begin
            flags_nxt[fli_pkg::FLAG_VIN_BIT] = 1'b1;
        end
        torch_pin_nxt = cfg1_r[fli_pkg::HW_TORCH_SEL_BIT] & p1_active; // see R01
        p1_req_nxt = ~cfg1_r[fli_pkg::HW_TORCH_SEL_BIT] & p1_active; // see R01
        trig_nxt = cfg1_r[fli_pkg::TRIGGER_EN_BIT] & trig_active; // see R05
        // alternate torch: armed only if pulse one leads the trigger
        alt_torch_nxt = alt_torch_r & cfg2_r[fli_pkg::ALT_TORCH_BIT];
        if (!p1_active || cfg1_r[fli_pkg::HW_TORCH_SEL_BIT]) begin
            alt_torch_nxt = 1'b0;
        end else if (!trig_nxt && !alt_torch_r) begin
            alt_torch_nxt = cfg2_r[fli_pkg::ALT_TORCH_BIT]; // see R08
        end
        torch_nxt = 1'b0;
        shut_nxt = 1'b0;
        if (vin_low_s && input_voltage_monitor_en) begin
            if (cfg2_r[fli_pkg::VIN_OFF_BIT]) shut_nxt = 1'b1; // see R07
            else torch_nxt = 1'b1; // see R07
        end
        if (therm_low_s && cfg1_r[fli_pkg::THERMAL_MODE_BIT]) begin
            if (cfg2_r[fli_pkg::THERMAL_OFF_BIT]) shut_nxt = 1'b1; // see R09
            else torch_nxt = 1'b1; // see R09
        end
        if (p2_active) begin
            if (cfg2_r[fli_pkg::PULSE_TWO_OFF_BIT]) shut_nxt = 1'b1; // see R10
            else torch_nxt = 1'b1; // see R10
        end
        torch_nxt = torch_nxt & ~shut_nxt; // shutdown dominates
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            state_r <= fli_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            oe_r <= 1'b0;
            rd_r <= 1'b0;
            cfg1_r <= fli_pkg::PIN_FUNCTION_CONFIG_RST;
            cfg2_r <= fli_pkg::FAULT_RESPONSE_CONFIG_RST;
            flags_r <= fli_pkg::FLAGS_RST;
            alt_torch_r <= 1'b0;
            torch_pin_enable_o <= 1'b0;
            pulse_one_torch_req_o <= 1'b0;
            strobe_trigger_o <= 1'b0;
            led_force_torch_o <= 1'b0;
            led_shutdown_o <= 1'b0;
        end else begin
            scl_d_r <= scl_d_nxt;
            sda_d_r <= sda_d_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            oe_r <= oe_nxt;
            rd_r <= rd_nxt;
            cfg1_r <= cfg1_nxt;
            cfg2_r <= cfg2_nxt;
            flags_r <= flags_nxt;
            alt_torch_r <= alt_torch_nxt;
            torch_pin_enable_o <= torch_pin_nxt;
            pulse_one_torch_req_o <= p1_req_nxt;
            strobe_trigger_o <= trig_nxt;
            led_force_torch_o <= torch_nxt;
            led_shutdown_o <= shut_nxt;
        end
    end

    assign scl_d_nxt = scl_s;
    assign sda_d_nxt = sda_s;
    assign sda_o = 1'b0; // open drain: only ever pulls low
    assign sda_oe = oe_r;
    assign torch_no_timeout_o = alt_torch_r;
    assign indicator_drive_en_o = ~cfg1_r[fli_pkg::THERMAL_MODE_BIT]; // see R06
    assign thermal_comp_en_o = cfg1_r[fli_pkg::THERMAL_MODE_BIT]; // see R06
    // checks
    chk_torch_sel_clear: assert property (@(posedge clk) disable iff (sys_rst) // see R02
        flash_event |=> !cfg1_r[fli_pkg::HW_TORCH_SEL_BIT])
        else $error("hardware torch select survived a flash event");
    chk_hw_torch_pin: assert property (@(posedge clk) disable iff (sys_rst) // see R01
        torch_pin_enable_o |-> $past(cfg1_r[fli_pkg::HW_TORCH_SEL_BIT] && p1_active))
        else $error("torch enable without torch selection");
    chk_pulse_one_mode: assert property (@(posedge clk) disable iff (sys_rst) // see R01
        pulse_one_torch_req_o |-> $past(!cfg1_r[fli_pkg::HW_TORCH_SEL_BIT]))
        else $error("pulse one request while in torch mode");
    chk_trigger_gate: assert property (@(posedge clk) disable iff (sys_rst) // see R05
        strobe_trigger_o |-> $past(cfg1_r[fli_pkg::TRIGGER_EN_BIT]))
        else $error("trigger passed while disabled");
    chk_vin_off: assert property (@(posedge clk) disable iff (sys_rst) // see R07
        (vin_low_s && input_voltage_monitor_en && cfg2_r[fli_pkg::VIN_OFF_BIT])
        |=> led_shutdown_o && !led_force_torch_o)
        else $error("undervoltage did not shut leds off");
    chk_thermal_torch: assert property (@(posedge clk) disable iff (sys_rst) // see R09
        (therm_low_s && cfg1_r[fli_pkg::THERMAL_MODE_BIT] && !cfg2_r[fli_pkg::THERMAL_OFF_BIT])
        |=> led_force_torch_o || led_shutdown_o)
        else $error("thermal trip ignored");
    chk_pulse_two_off: assert property (@(posedge clk) disable iff (sys_rst) // see R10
        (p2_active && cfg2_r[fli_pkg::PULSE_TWO_OFF_BIT]) |=> led_shutdown_o)
        else $error("pulse two shutdown missing");
    chk_alt_torch_hold: assert property (@(posedge clk) disable iff (sys_rst) // see R08
        torch_no_timeout_o |-> p1_active || $past(p1_active))
        else $error("no-timeout torch without pulse one");
    chk_unused_zero: assert property (@(posedge clk) disable iff (sys_rst) // see R11
        cfg1_r[1:0] == 2'h0 && cfg2_r[7:4] == 4'h0)
        else $error("unused configuration bits set");
    chk_p1_flag: assert property (@(posedge clk) disable iff (sys_rst) // see R12
        p1_changed && !cfg1_r[fli_pkg::HW_TORCH_SEL_BIT] |=> flags_r[fli_pkg::FLAG_PULSE_ONE_BIT])
        else $error("pulse one change not flagged");
    cov_cfg_write: cover property (@(posedge clk) disable iff (sys_rst) wr_stb);
    cov_flags_read: cover property (@(posedge clk) disable iff (sys_rst) flags_rd);
    cov_alt_torch: cover property (@(posedge clk) disable iff (sys_rst) $rose(alt_torch_r));
    cov_flash_clear: cover property (@(posedge clk) disable iff (sys_rst)
        flash_event && cfg1_r[fli_pkg::HW_TORCH_SEL_BIT]);
endmodule : fli_ctrl

// [dv/fli_host.sv]
// host model: drives the serial register bus as bus master at a 125 ns bit period
// assumes a pull-up on sda; sda_pull high means the host pulls the line low
`timescale 1ns/10ps
module fli_host (
    output logic scl,
    output logic sda_pull,
    input wire logic sda,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    localparam real HQ = 31.25; // quarter of the bit period
    // idle bus: both lines released high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_data = 8'h00;
        rd_valid = 1'b0;
    end
    // data only changes while scl is low
    task automatic bit_out(input logic b);
        sda_pull = ~b;
        #HQ scl = 1'b1;
        #(2*HQ) scl = 1'b0;
        #HQ;
    endtask : bit_out
    task automatic bit_in(output logic b);
        sda_pull = 1'b0;
        #HQ scl = 1'b1;
        #HQ b = sda;
        #HQ scl = 1'b0;
        #HQ;
    endtask : bit_in
    task automatic start();
        sda_pull = 1'b0;
        #HQ scl = 1'b1;
        #HQ sda_pull = 1'b1;
        #HQ scl = 1'b0;
        #HQ;
    endtask : start
    task automatic stop();
        sda_pull = 1'b1;
        #HQ scl = 1'b1;
        #HQ sda_pull = 1'b0;
        #(4*HQ);
    endtask : stop
    // a missing acknowledge is accumulated in nak
    task automatic byte_out(input logic [7:0] d, inout logic nak);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
        nak = nak | a;
    endtask : byte_out
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] off,
                             input logic [7:0] d, output logic nak);
        nak = 1'b0;
        start();
        byte_out({dev, 1'b0}, nak);
        byte_out(off, nak);
        byte_out(d, nak);
        stop();
    endtask : write_reg
    // read ends with a nack so the device lets go of the line
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] off, output logic nak);
        logic b;
        nak = 1'b0;
        start();
        byte_out({dev, 1'b0}, nak);
        byte_out(off, nak);
        start();
        byte_out({dev, 1'b1}, nak);
        for (int i = 7; i >= 0; i--) begin
            bit_in(b);
            rd_data[i] = b;
        end
        bit_out(1'b1);
        stop();
        rd_valid = 1'b1;
        #1 rd_valid = 1'b0;
    endtask : read_reg
endmodule : fli_host

// [dv/tb.sv]
// testbench for fli_ctrl: register access through the host model, pin steering checks
// assumes a 100 MHz clk and a pulled-up open-drain sda shared with the host model
`timescale 1ns/10ps
module tb;
    logic clk, sys_rst, fev, nak;
    logic uv, mon, therm, p2, torch, trig;
    logic [31:0] rng;
    logic [7:0] exp_q[$];
    int err_count, check_count;
    wire scl, sda_pull, sda_o, sda_oe, rd_valid;
    wire [7:0] rd_data;
    wire ten, p1r, stb, ind, thc, ftorch, sd, nto;
    wire sda = !(sda_pull || (sda_oe && !sda_o)); // wired-and with pull-up
    localparam logic [6:0] DEV = fli_pkg::DEV_ADDR_DEFAULT;
    localparam logic [7:0] C1 = fli_pkg::PIN_FUNCTION_CONFIG_ADDR;
    localparam logic [7:0] C2 = fli_pkg::FAULT_RESPONSE_CONFIG_ADDR;
    // fault table: cfg1, cfg2, pins {uv,mon,therm,p2}, expected {torch,shutdown}
    localparam logic [21:0] TBL[9] = '{
        {8'h68, 8'h00, 4'h1, 2'b10}, {8'h68, 8'h01, 4'h1, 2'b01},
        {8'h28, 8'h00, 4'h0, 2'b10}, {8'h78, 8'h00, 4'h2, 2'b10},
        {8'h78, 8'h02, 4'h2, 2'b01}, {8'h68, 8'h02, 4'h2, 2'b00},
        {8'h68, 8'h00, 4'hc, 2'b10}, {8'h68, 8'h08, 4'hc, 2'b01},
        {8'h68, 8'h08, 4'h8, 2'b00}};
    fli_host fli_host_i (.scl(scl), .sda_pull(sda_pull), .sda(sda), .rd_data(rd_data),
        .rd_valid(rd_valid));
    fli_ctrl fli_ctrl_i (.clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .torch_or_pulse_one_pin(torch), .pulse_input_two(p2),
        .flash_trigger_pin(trig), .led_thermal_sense(therm), .input_undervoltage_threshold(uv),
        .input_voltage_monitor_en(mon), .flash_event(fev), .torch_pin_enable_o(ten),
        .pulse_one_torch_req_o(p1r), .strobe_trigger_o(stb), .indicator_drive_en_o(ind),
        .thermal_comp_en_o(thc), .led_force_torch_o(ftorch), .led_shutdown_o(sd),
        .torch_no_timeout_o(nto));
    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        fli_host_i.write_reg(DEV, off, d, nak);
        check({7'h0, nak}, 8'h00);
    endtask : wr
    // the expected byte is noted first; the monitor compares when the read completes
    task automatic rd(input logic [7:0] off, input logic [7:0] e);
        exp_q.push_back(e);
        fli_host_i.read_reg(DEV, off, nak);
    endtask : rd
    // pins change one small delay after the edge, then settle past the sync latency
    task automatic pins(input logic [5:0] v);
        @(posedge clk);
        #1 {uv, mon, therm, p2, torch, trig} = v;
        repeat (6) @(posedge clk);
    endtask : pins
    // monitor: each completed read is matched against the oldest note
    always @(posedge rd_valid) begin
        if (exp_q.size() == 0) check(rd_data, 8'hxx);
        else check(rd_data, exp_q.pop_front());
    end
    // watchdog sized well above the expected run of about 18500 cycles
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        print_verdict();
    end
    initial begin
        {uv, mon, therm, p2, torch, trig, fev} = 7'h00;
        rng = 32'h4086;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (5) @(posedge clk);
        check({6'h0, ind, thc}, 8'h02);
        rd(C1, 8'h68);
        rd(C2, 8'h00);
        rd(8'h10, 8'h00);
        wr(C1, 8'hff);
        rd(C1, 8'hfc);
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            wr(C2, rng[7:0] & fli_pkg::FAULT_RESPONSE_CONFIG_MASK);
            rd(C2, rng[7:0] & fli_pkg::FAULT_RESPONSE_CONFIG_MASK);
        end
        fli_host_i.write_reg(DEV ^ 7'h01, C2, 8'h05, nak);
        check({7'h0, nak}, 8'h01);
        rd(C2, rng[7:0] & fli_pkg::FAULT_RESPONSE_CONFIG_MASK);
        // polarity of pulse one and trigger with the trigger enabled, each level against each pin state
        for (int p = 0; p < 2; p++) begin
            for (int v = 0; v < 2; v++) begin
                wr(C1, {2'b01, p[0], 1'b0, p[0], 3'b100});
                pins({4'h0, v[0], v[0]});
                check({5'h0, p1r, stb, ten}, {5'h0, v == p, v == p, 1'b0});
            end
        end
        wr(C1, 8'he8);
        pins(6'h03);
        check({5'h0, p1r, stb, ten}, 8'h01);
        @(posedge clk);
        #1 fev = 1'b1;
        @(posedge clk);
        #1 fev = 1'b0;
        rd(C1, 8'h68);
        pins(6'h00);
        rd(fli_pkg::FLAGS_ADDR, 8'h08);
        for (int i = 0; i < 9; i++) begin
            wr(C1, TBL[i][21:14]);
            wr(C2, TBL[i][13:6]);
            pins({TBL[i][5:2], 2'b00});
            check({6'h0, ftorch, sd}, {6'h0, TBL[i][1:0]});
            check({6'h0, ind, thc}, {6'h0, !TBL[i][18], TBL[i][18]});
            pins(6'h00);
        end
        wr(C1, 8'h68);
        rd(fli_pkg::FLAGS_ADDR, 8'hb0);
        rd(fli_pkg::FLAGS_ADDR, 8'h00);
        wr(C2, 8'h04);
        pins(6'h02);
        check({7'h0, nto}, 8'h01);
        pins(6'h00);
        check({7'h0, nto}, 8'h00);
        // trigger already active when pulse one rises: no hold-on torch
        wr(C1, 8'h6c);
        pins(6'h01);
        pins(6'h03);
        check({7'h0, nto}, 8'h00);
        print_verdict();
    end
endmodule : tb
